// ---- verilog/ocg_pkg.sv ----
// Constants and types shared by the oscillator trim and clock generation block
package ocg_pkg;
    localparam int CORE_CLK_MHZ      = 200;
    localparam int TRIM_UNIT_US      = 250;
    localparam int TRIM_UNIT_CYCLES  = TRIM_UNIT_US * CORE_CLK_MHZ;

    localparam int TRIM_W            = 11;
    localparam int FINE_W            = 8;
    localparam int COARSE_W          = 3;
    localparam int COARSE_LSB        = 8;
    localparam int THERMO_W          = 7;
    localparam logic [10:0] TRIM_MAX_CAP = 11'h000;

    localparam int SEQ_FIELD_W       = 4;

    localparam int CAL_SEL_W         = 16;
    localparam int CAL_START_BIT     = 2;
    localparam int CAL_SRC_LSB       = 0;
    localparam int CAL_SRC_W         = 2;
    localparam logic [1:0] SRC_SLOW_RC   = 2'h0;
    localparam logic [1:0] SRC_FAST_RC   = 2'h1;
    localparam logic [1:0] SRC_SLOW_XTAL = 2'h2;
    localparam logic [1:0] SRC_ENH_RC    = 2'h3;
    localparam int CAL_N_W           = 16;
    localparam int CAL_M_W           = 32;
    localparam int CAL_HALF_W        = 16;

    localparam int FAST_RC_TRIM_W    = 4;
    localparam logic [3:0] FAST_RC_TRIM_RESET = 4'h0;

    localparam int NUM_PERIPH        = 8;
    localparam int PERIPH_SPI        = 0;
    localparam int SPI_SEL_W         = 2;
    localparam int SPI_HALF_W        = 3;
    localparam logic [2:0] SPI_HALF_DIV2  = 3'h1;
    localparam logic [2:0] SPI_HALF_DIV4  = 3'h2;
    localparam logic [2:0] SPI_HALF_DIV8  = 3'h4;
    localparam logic [2:0] SPI_HALF_DIV14 = 3'h7;

    localparam int STAT_TRIM_BIT     = 0;
    localparam int STAT_SETTLED_BIT  = 1;
    localparam int STAT_W            = 2;

    typedef enum logic [1:0] {
        OCG_SEQ_IDLE   = 2'b00,
        OCG_SEQ_DELAY  = 2'b01,
        OCG_SEQ_SETTLE = 2'b10,
        OCG_SEQ_DONE   = 2'b11
    } ocg_seq_type;

    typedef enum logic [1:0] {
        OCG_CAL_IDLE = 2'b00,
        OCG_CAL_ARM  = 2'b01,
        OCG_CAL_RUN  = 2'b10
    } ocg_cal_type;
endpackage : ocg_pkg

// ---- verilog/ocg_top.sv ----
// Crystal trim, trim sequencer, reference counter and peripheral clock control
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Trim 0x000 max capacitance, 0x7FF minimum
// - Low eight trim bits drive capacitors directly
// - Top three bits thermometer decoded, seven switches
// - Delay count in 250 us, then apply
// - Zero delay applies trim at crystal start
// - Settle count after apply, then settled flag
// - Reference counter selects oscillator by code
// - Measurement length is N selected cycles
// - Start bit begins, cleared when measurement done
// - 32-bit crystal count M in halves
// - Each clock via divider or gate, stoppable
// - One control word gates peripheral clocks
// - Serial interface clock divided 2,4,8,14
// - Fast RC trim resets to minimum value
// - Fast RC clocks system while crystal settles
// - Slow crystal untrimmed, clocks deep sleep
module ocg_top #(
    parameter int TRIM_UNIT_CYCLES = ocg_pkg::TRIM_UNIT_CYCLES,
    parameter int NUM_PERIPH       = ocg_pkg::NUM_PERIPH
) (
    input  wire logic                                core_clk,
    input  wire logic                                rst_n,
    input  wire logic [ocg_pkg::TRIM_W-1:0]          xtal_trim_word,
    input  wire logic                                fast_crystal_en,
    input  wire logic [ocg_pkg::SEQ_FIELD_W-1:0]     trim_delay_units,
    input  wire logic [ocg_pkg::SEQ_FIELD_W-1:0]     settle_delay_units,
    output logic      [ocg_pkg::FINE_W-1:0]          fine_cap_switch,
    output logic      [ocg_pkg::THERMO_W-1:0]        coarse_cap_switch,
    output logic      [ocg_pkg::STAT_W-1:0]          system_status_word,
    input  wire logic                                fast_crystal_osc,
    input  wire logic                                slow_crystal_osc,
    input  wire logic                                fast_rc_osc,
    input  wire logic                                slow_rc_osc,
    input  wire logic                                enhanced_rc_osc,
    input  wire logic [ocg_pkg::CAL_N_W-1:0]         calib_length_n,
    input  wire logic                                calib_sel_we,
    input  wire logic [ocg_pkg::CAL_SEL_W-1:0]       calib_sel_wdata,
    output logic      [ocg_pkg::CAL_SEL_W-1:0]       calib_sel_word,
    output logic      [ocg_pkg::CAL_HALF_W-1:0]      calib_result_high,
    output logic      [ocg_pkg::CAL_HALF_W-1:0]      calib_result_low,
    input  wire logic [NUM_PERIPH-1:0]               periph_clock_gates,
    input  wire logic [ocg_pkg::SPI_SEL_W-1:0]       spi_clk_div_sel,
    output logic      [NUM_PERIPH-1:0]               periph_clk_enable,
    output logic                                     spi_clk_div,
    input  wire logic                                fast_rc_config_we,
    input  wire logic [ocg_pkg::FAST_RC_TRIM_W-1:0]  fast_rc_config_wdata,
    output logic      [ocg_pkg::FAST_RC_TRIM_W-1:0]  fast_rc_trim_field,
    input  wire logic                                fuse_mirror_busy,
    input  wire logic                                deep_sleep,
    output logic                                     sys_clk_from_crystal,
    output logic                                     sleep_clk_from_slow_xtal
);
    localparam int TICK_W = $clog2(TRIM_UNIT_CYCLES + 1);

    function automatic logic [ocg_pkg::THERMO_W-1:0] thermo_decode(
        input logic [ocg_pkg::COARSE_W-1:0] code
    );
        logic [ocg_pkg::THERMO_W-1:0] res;
        res = '0;
        for (int k = 0; k < ocg_pkg::THERMO_W; k++) begin
            res[k] = (k == 0) || (int'(code) > k);
        end
        return res;
    endfunction : thermo_decode

    function automatic logic [ocg_pkg::SPI_HALF_W-1:0] spi_half(
        input logic [ocg_pkg::SPI_SEL_W-1:0] sel
    );
        logic [ocg_pkg::SPI_HALF_W-1:0] res;
        res = ocg_pkg::SPI_HALF_DIV2;
        case (sel)
            2'h0: res = ocg_pkg::SPI_HALF_DIV2;
            2'h1: res = ocg_pkg::SPI_HALF_DIV4;
            2'h2: res = ocg_pkg::SPI_HALF_DIV8;
            default: res = ocg_pkg::SPI_HALF_DIV14;
        endcase
        return res;
    endfunction : spi_half

    // Shared by the delay and settle phases so both end on the same tick count
    function automatic logic units_done(
        input logic [ocg_pkg::SEQ_FIELD_W-1:0] count,
        input logic [ocg_pkg::SEQ_FIELD_W-1:0] target
    );
        return (count + 4'h1) >= target;
    endfunction : units_done

    function automatic logic [ocg_pkg::SPI_HALF_W-1:0] spi_step(
        input logic [ocg_pkg::SPI_HALF_W-1:0] count
    );
        return count + 3'h1;
    endfunction : spi_step

    // Trim sequencer
    ocg_pkg::ocg_seq_type            seq_q;
    logic [TICK_W-1:0]               tick_cnt_q;
    logic [ocg_pkg::SEQ_FIELD_W-1:0] unit_cnt_q;
    logic                            trim_applied_q;
    logic                            settled_q;
    logic                            tick;

    assign tick = (tick_cnt_q == TICK_W'(TRIM_UNIT_CYCLES - 1));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
        end else if (!fast_crystal_en || seq_q == ocg_pkg::OCG_SEQ_IDLE || tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_q          <= ocg_pkg::OCG_SEQ_IDLE;
            unit_cnt_q     <= '0;
            trim_applied_q <= 1'b0;
            settled_q      <= 1'b0;
        end else if (!fast_crystal_en) begin
            seq_q          <= ocg_pkg::OCG_SEQ_IDLE;
            unit_cnt_q     <= '0;
            trim_applied_q <= 1'b0;
            settled_q      <= 1'b0;
        end else begin
            case (seq_q)
                ocg_pkg::OCG_SEQ_IDLE: begin
                    unit_cnt_q <= '0;
                    if (trim_delay_units == '0) begin
                        trim_applied_q <= 1'b1;
                        seq_q          <= ocg_pkg::OCG_SEQ_SETTLE;
                    end else begin
                        seq_q <= ocg_pkg::OCG_SEQ_DELAY;
                    end
                end
                ocg_pkg::OCG_SEQ_DELAY: begin
                    if (tick) begin
                        if (units_done(unit_cnt_q, trim_delay_units)) begin
                            trim_applied_q <= 1'b1;
                            unit_cnt_q     <= '0;
                            seq_q          <= ocg_pkg::OCG_SEQ_SETTLE;
                        end else begin
                            unit_cnt_q <= unit_cnt_q + 4'h1;
                        end
                    end
                end
                ocg_pkg::OCG_SEQ_SETTLE: begin
                    if (settle_delay_units == '0) begin
                        settled_q <= 1'b1;
                        seq_q     <= ocg_pkg::OCG_SEQ_DONE;
                    end else if (tick) begin
                        if (units_done(unit_cnt_q, settle_delay_units)) begin
                            settled_q <= 1'b1;
                            seq_q     <= ocg_pkg::OCG_SEQ_DONE;
                        end else begin
                            unit_cnt_q <= unit_cnt_q + 4'h1;
                        end
                    end
                end
                default: begin
                    seq_q <= ocg_pkg::OCG_SEQ_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            system_status_word <= '0;
        end else begin
            system_status_word[ocg_pkg::STAT_TRIM_BIT]    <= trim_applied_q;
            system_status_word[ocg_pkg::STAT_SETTLED_BIT] <= settled_q;
        end
    end

    // Capacitor switches; untrimmed crystal sits at maximum load until applied
    logic [ocg_pkg::TRIM_W-1:0] eff_trim;
    assign eff_trim = trim_applied_q ? xtal_trim_word : ocg_pkg::TRIM_MAX_CAP;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fine_cap_switch   <= '0;
            coarse_cap_switch <= '0;
        end else begin
            fine_cap_switch   <= eff_trim[ocg_pkg::FINE_W-1:0];
            coarse_cap_switch <= thermo_decode(
                eff_trim[ocg_pkg::COARSE_LSB +: ocg_pkg::COARSE_W]);
        end
    end

    // Reference counter; all oscillator inputs are sampled levels
    logic [4:0] osc_prev_q;
    logic [4:0] osc_now;
    logic [4:0] osc_rise;
    assign osc_now  = {enhanced_rc_osc, slow_crystal_osc, fast_rc_osc, slow_rc_osc,
                       fast_crystal_osc};
    assign osc_rise = osc_now & ~osc_prev_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev_q <= '0;
        end else begin
            osc_prev_q <= osc_now;
        end
    end

    ocg_pkg::ocg_cal_type            cal_q;
    logic [ocg_pkg::CAL_SRC_W-1:0]   cal_src_q;
    logic [ocg_pkg::CAL_N_W-1:0]     cal_n_q;
    logic [ocg_pkg::CAL_N_W-1:0]     cal_ncnt_q;
    logic [ocg_pkg::CAL_M_W-1:0]     cal_mcnt_q;
    logic                            src_rise;
    logic                            xtal_rise;
    logic [ocg_pkg::CAL_M_W-1:0]     m_next;

    assign xtal_rise = osc_rise[0];
    always_comb begin
        src_rise = 1'b0;
        case (cal_src_q)
            ocg_pkg::SRC_SLOW_RC:   src_rise = osc_rise[1];
            ocg_pkg::SRC_FAST_RC:   src_rise = osc_rise[2];
            ocg_pkg::SRC_SLOW_XTAL: src_rise = osc_rise[3];
            default:                src_rise = osc_rise[4];
        endcase
    end
    assign m_next = cal_mcnt_q + {{(ocg_pkg::CAL_M_W-1){1'b0}}, xtal_rise};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_q             <= ocg_pkg::OCG_CAL_IDLE;
            cal_src_q         <= '0;
            cal_n_q           <= '0;
            cal_ncnt_q        <= '0;
            cal_mcnt_q        <= '0;
            calib_sel_word    <= '0;
            calib_result_high <= '0;
            calib_result_low  <= '0;
        end else begin
            case (cal_q)
                ocg_pkg::OCG_CAL_IDLE: begin
                    // Writes during a measurement are dropped to keep M consistent
                    if (calib_sel_we) begin
                        calib_sel_word <= calib_sel_wdata;
                        cal_src_q      <= calib_sel_wdata[ocg_pkg::CAL_SRC_LSB +:
                                                          ocg_pkg::CAL_SRC_W];
                        cal_n_q        <= calib_length_n;
                        if (calib_sel_wdata[ocg_pkg::CAL_START_BIT]) begin
                            cal_q <= ocg_pkg::OCG_CAL_ARM;
                        end
                    end
                end
                ocg_pkg::OCG_CAL_ARM: begin
                    cal_ncnt_q <= '0;
                    cal_mcnt_q <= '0;
                    if (cal_n_q == '0) begin
                        calib_result_high <= '0;
                        calib_result_low  <= '0;
                        calib_sel_word[ocg_pkg::CAL_START_BIT] <= 1'b0;
                        cal_q <= ocg_pkg::OCG_CAL_IDLE;
                    end else if (src_rise) begin
                        cal_q <= ocg_pkg::OCG_CAL_RUN;
                    end
                end
                ocg_pkg::OCG_CAL_RUN: begin
                    cal_mcnt_q <= m_next;
                    if (src_rise) begin
                        if (cal_ncnt_q + 16'h0001 == cal_n_q) begin
                            calib_result_high <= m_next[ocg_pkg::CAL_M_W-1 -: ocg_pkg::CAL_HALF_W];
                            calib_result_low  <= m_next[ocg_pkg::CAL_HALF_W-1:0];
                            calib_sel_word[ocg_pkg::CAL_START_BIT] <= 1'b0;
                            cal_q <= ocg_pkg::OCG_CAL_IDLE;
                        end else begin
                            cal_ncnt_q <= cal_ncnt_q + 16'h0001;
                        end
                    end
                end
                default: begin
                    cal_q <= ocg_pkg::OCG_CAL_IDLE;
                end
            endcase
        end
    end

    // Peripheral clock gates and serial interface divider
    logic [ocg_pkg::SPI_HALF_W-1:0] spi_cnt_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_clk_enable <= '0;
        end else begin
            periph_clk_enable <= periph_clock_gates;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            spi_cnt_q   <= '0;
            spi_clk_div <= 1'b0;
        end else if (!periph_clock_gates[ocg_pkg::PERIPH_SPI]) begin
            spi_cnt_q   <= '0;
            spi_clk_div <= 1'b0;
        end else if (spi_step(spi_cnt_q) >= spi_half(spi_clk_div_sel)) begin
            spi_cnt_q   <= '0;
            spi_clk_div <= ~spi_clk_div;
        end else begin
            spi_cnt_q <= spi_step(spi_cnt_q);
        end
    end

    // Fast RC trim and clock source selection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_rc_trim_field <= ocg_pkg::FAST_RC_TRIM_RESET;
        end else if (fast_rc_config_we) begin
            fast_rc_trim_field <= fast_rc_config_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_clk_from_crystal     <= 1'b0;
            sleep_clk_from_slow_xtal <= 1'b0;
        end else begin
            // Fast RC stays in use until the crystal is trimmed and settled and the fuse mirror is no longer busy
            sys_clk_from_crystal     <= settled_q && !fuse_mirror_busy;
            sleep_clk_from_slow_xtal <= deep_sleep;
        end
    end
endmodule : ocg_top

`default_nettype wire

// ---- bench/ocg_top_sva.sv ----
// Assertion checker for the oscillator trim and clock generation block
`timescale 1ns/1ps
`default_nettype none
module ocg_top_sva #(
    parameter int TRIM_UNIT_CYCLES = 8,
    parameter int NUM_PERIPH       = 8
) (
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire logic [10:0]           xtal_trim_word,
    input wire logic                  fast_crystal_en,
    input wire logic [3:0]            trim_delay_units,
    input wire logic [7:0]            fine_cap_switch,
    input wire logic [6:0]            coarse_cap_switch,
    input wire logic [1:0]            system_status_word,
    input wire logic                  calib_sel_we,
    input wire logic [15:0]           calib_sel_wdata,
    input wire logic [15:0]           calib_sel_word,
    input wire logic [15:0]           calib_result_high,
    input wire logic [15:0]           calib_result_low,
    input wire logic [NUM_PERIPH-1:0] periph_clock_gates,
    input wire logic [NUM_PERIPH-1:0] periph_clk_enable,
    input wire logic                  spi_clk_div,
    input wire logic                  fuse_mirror_busy,
    input wire logic                  sys_clk_from_crystal
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Crystal enable is required too; switches fall back on the same edge that status drops
    property p_fine;
        system_status_word[0] && $past(system_status_word[0]) && fast_crystal_en
            && $past(fast_crystal_en) |-> fine_cap_switch == $past(xtal_trim_word[7:0]);
    endproperty
    a_fine: assert property (p_fine) else $error("fine switches wrong");
    property p_coarse;
        system_status_word[0] && $past(system_status_word[0]) && fast_crystal_en
            && $past(fast_crystal_en) |-> coarse_cap_switch == ($past(xtal_trim_word[10:8])
            == 3'h0 ? 7'h01 : 7'h7F >> (3'h7 - $past(xtal_trim_word[10:8])));
    endproperty
    a_coarse: assert property (p_coarse) else $error("coarse switches wrong");
    property p_zero_delay;
        $rose(fast_crystal_en) && trim_delay_units == 4'h0 |-> ##[1:5] system_status_word[0];
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay late");
    property p_order;
        system_status_word[1] |-> system_status_word[0];
    endproperty
    a_order: assert property (p_order) else $error("settled before trim");
    property p_clear;
        !fast_crystal_en [*2] |=> system_status_word == 2'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");
    property p_store;
        calib_sel_we && !calib_sel_word[2] |=> calib_sel_word == $past(calib_sel_wdata);
    endproperty
    a_store: assert property (p_store) else $error("select not stored");
    property p_busy;
        calib_sel_we && calib_sel_word[2] |=> calib_sel_word[1:0] == $past(calib_sel_word[1:0]);
    endproperty
    a_busy: assert property (p_busy) else $error("busy write taken");
    property p_hold;
        calib_sel_word[2] ##1 calib_sel_word[2] |-> $stable({calib_result_high, calib_result_low});
    endproperty
    a_hold: assert property (p_hold) else $error("result moved while busy");
    property p_gates;
        1'b1 |=> periph_clk_enable == $past(periph_clock_gates);
    endproperty
    a_gates: assert property (p_gates) else $error("gate word not followed");
    property p_spi_off;
        !periph_clock_gates[0] [*2] |=> !spi_clk_div;
    endproperty
    a_spi_off: assert property (p_spi_off) else $error("divider not stopped");
    property p_sysclk;
        sys_clk_from_crystal |-> system_status_word[1] && !$past(fuse_mirror_busy);
    endproperty
    a_sysclk: assert property (p_sysclk) else $error("crystal clock too early");
endmodule : ocg_top_sva
`default_nettype wire

// ---- bench/test_osc_trim_and_clock_gen.sv ----
// Self-checking testbench for the oscillator trim and clock generation block
`timescale 1ns/1ps
`default_nettype none
module test_osc_trim_and_clock_gen;
    localparam int UNIT = 8;
    localparam int HALF [4] = '{1, 2, 4, 7};
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [10:0] xtal_trim_word = 11'h000;
    logic        fast_crystal_en = 1'b0;
    logic [3:0]  trim_delay_units = 4'h0;
    logic [3:0]  settle_delay_units = 4'h0;
    logic [15:0] calib_length_n = 16'h0000;
    logic        calib_sel_we = 1'b0;
    logic [15:0] calib_sel_wdata = 16'h0000;
    logic [7:0]  periph_clock_gates = 8'h00;
    logic [1:0]  spi_clk_div_sel = 2'h0;
    logic        fast_rc_config_we = 1'b0;
    logic [3:0]  fast_rc_config_wdata = 4'h0;
    logic        fuse_mirror_busy = 1'b0;
    logic        deep_sleep = 1'b0;
    logic [4:0]  cyc = 5'h00;
    logic [1:0]  src = 2'h0;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    // Crystal rises on odd cycles, sources on even ones, so M is exactly 8 per source period
    wire         fast_crystal_osc = cyc[0];
    wire         slow_rc_osc = (src == 2'h0) ? cyc[3] : cyc[4];
    wire         fast_rc_osc = (src == 2'h1) ? cyc[3] : cyc[4];
    wire         slow_crystal_osc = (src == 2'h2) ? cyc[3] : cyc[4];
    wire         enhanced_rc_osc = (src == 2'h3) ? cyc[3] : cyc[4];
    logic [7:0]  fine_cap_switch;
    logic [6:0]  coarse_cap_switch;
    logic [1:0]  system_status_word;
    logic [15:0] calib_sel_word;
    logic [15:0] calib_result_high;
    logic [15:0] calib_result_low;
    logic [7:0]  periph_clk_enable;
    logic        spi_clk_div;
    logic [3:0]  fast_rc_trim_field;
    logic        sys_clk_from_crystal;
    logic        sleep_clk_from_slow_xtal;

    ocg_top #(.TRIM_UNIT_CYCLES(UNIT)) u_ocg_top (
        .core_clk, .rst_n, .xtal_trim_word, .fast_crystal_en, .trim_delay_units,
        .settle_delay_units, .fine_cap_switch, .coarse_cap_switch, .system_status_word,
        .fast_crystal_osc, .slow_crystal_osc, .fast_rc_osc, .slow_rc_osc, .enhanced_rc_osc,
        .calib_length_n, .calib_sel_we, .calib_sel_wdata, .calib_sel_word,
        .calib_result_high, .calib_result_low, .periph_clock_gates, .spi_clk_div_sel,
        .periph_clk_enable, .spi_clk_div, .fast_rc_config_we, .fast_rc_config_wdata,
        .fast_rc_trim_field, .fuse_mirror_busy, .deep_sleep, .sys_clk_from_crystal,
        .sleep_clk_from_slow_xtal
    );

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) cyc <= cyc + 5'h01;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    function automatic logic hit(input int w);
        case (w)
            0: return system_status_word[0] === 1'b1;
            1: return system_status_word[1] === 1'b1;
            default: return calib_sel_word[2] === 1'b0;
        endcase
    endfunction : hit
    task automatic wait_for(input int w, input int lim, output int n);
        n = 0;
        while (!hit(w) && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_for
    task automatic wr_sel(input logic [15:0] d);
        calib_sel_wdata = d;
        calib_sel_we = 1'b1;
        tick(1);
        calib_sel_we = 1'b0;
        tick(1);
    endtask : wr_sel

    task automatic t_seq;
        int n;
        xtal_trim_word = 11'h7FF;
        trim_delay_units = 4'h2;
        settle_delay_units = 4'hF;
        fuse_mirror_busy = 1'b1;
        fast_crystal_en = 1'b1;
        tick(2);
        check({coarse_cap_switch, fine_cap_switch}, 15'h0100);
        wait_for(0, 4 * UNIT, n);
        check(n >= 2 * UNIT - 3 && n <= 2 * UNIT + 2, 1'b1);
        for (int c = 7; c >= 0; c--) begin
            xtal_trim_word = {c[2:0], 8'hA5 ^ c[7:0]};
            tick(2);
            check(fine_cap_switch, 8'hA5 ^ c[7:0]);
            check(coarse_cap_switch, c == 0 ? 7'h01 : 7'h7F >> (7 - c));
        end
        check(system_status_word, 2'h1);
        wait_for(1, 20 * UNIT, n);
        check(n >= 14 * UNIT - 17 && n <= 15 * UNIT - 15, 1'b1);
        check(sys_clk_from_crystal, 1'b0);
        fuse_mirror_busy = 1'b0;
        tick(2);
        check(sys_clk_from_crystal, 1'b1);
        fast_crystal_en = 1'b0;
        tick(3);
        check(system_status_word, 2'h0);
        trim_delay_units = 4'h0;
        settle_delay_units = 4'h0;
        fast_crystal_en = 1'b1;
        wait_for(0, 8, n);
        check(n <= 4, 1'b1);
        wait_for(1, 8, n);
        check(n <= 2, 1'b1);
        check(system_status_word, 2'h3);
        fast_crystal_en = 1'b0;
        tick(3);
    endtask : t_seq

    task automatic t_cal;
        int n;
        for (int s = 0; s < 4; s++) begin
            src = s[1:0];
            calib_length_n = 16'(s + 2);
            wr_sel({13'h0000, 1'b1, s[1:0]});
            check(calib_sel_word, {13'h0000, 1'b1, s[1:0]});
            // N is latched at the write, so a later change must not lengthen the count
            calib_length_n = 16'h0009;
            wr_sel({13'h0000, 1'b1, ~s[1:0]});
            wait_for(2, 300, n);
            check(calib_sel_word, {14'h0000, s[1:0]});
            check({calib_result_high, calib_result_low}, 32'(8 * (s + 2)));
        end
        calib_length_n = 16'h0000;
        wr_sel(16'h0005);
        wait_for(2, 20, n);
        check({calib_result_high, calib_result_low}, 32'h0);
        wr_sel(16'h0003);
        check(calib_sel_word, 16'h0003);
    endtask : t_cal

    task automatic t_clk;
        int n;
        logic v;
        periph_clock_gates = 8'hA5;
        tick(2);
        check(periph_clk_enable, 8'hA5);
        for (int s = 0; s < 4; s++) begin
            spi_clk_div_sel = s[1:0];
            tick(16);
            for (int k = 0; k < 2; k++) begin
                v = spi_clk_div;
                n = 0;
                while (spi_clk_div === v && n < 20) begin
                    tick(1);
                    n++;
                end
            end
            check(n, HALF[s]);
        end
        periph_clock_gates = 8'h5A;
        tick(3);
        check(spi_clk_div, 1'b0);
        check(periph_clk_enable, 8'h5A);
        periph_clock_gates = 8'h01;
        tick(4);
        v = spi_clk_div;
        n = 0;
        while (spi_clk_div === v && n < 20) begin
            tick(1);
            n++;
        end
        check(n, HALF[3] - 4);
    endtask : t_clk

    task automatic t_misc;
        fast_rc_config_wdata = 4'h9;
        fast_rc_config_we = 1'b1;
        tick(1);
        fast_rc_config_we = 1'b0;
        tick(1);
        check(fast_rc_trim_field, 4'h9);
        deep_sleep = 1'b1;
        tick(2);
        check(sleep_clk_from_slow_xtal, 1'b1);
        deep_sleep = 1'b0;
        tick(2);
        check(sleep_clk_from_slow_xtal, 1'b0);
        rst_n = 1'b0;
        tick(1);
        check(fast_rc_trim_field, 4'h0);
        rst_n = 1'b1;
        tick(1);
    endtask : t_misc

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    initial begin
        tick(2);
        check(system_status_word, 2'h0);
        check(fast_rc_trim_field, 4'h0);
        rst_n = 1'b1;
        tick(1);
        t_seq;
        t_cal;
        t_clk;
        t_misc;
        conclude;
    end
endmodule : test_osc_trim_and_clock_gen

bind ocg_top ocg_top_sva #(.TRIM_UNIT_CYCLES(TRIM_UNIT_CYCLES), .NUM_PERIPH(NUM_PERIPH)) u_sva (
    .core_clk, .rst_n, .xtal_trim_word, .fast_crystal_en, .trim_delay_units,
    .fine_cap_switch, .coarse_cap_switch, .system_status_word, .calib_sel_we,
    .calib_sel_wdata, .calib_sel_word, .calib_result_high, .calib_result_low,
    .periph_clock_gates, .periph_clk_enable, .spi_clk_div, .fuse_mirror_busy,
    .sys_clk_from_crystal
);
`default_nettype wire
